/* hdl/ados_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Pins carry carrier keyed by envelope
// - Carrier is system clock divided by two
// - Driver control bits set both pin behaviours
// - Disabled driver ignores bits, pin held low
// - Envelope picks steady or keyed conductance
// - Pin one forced low on full-depth keying
// - Pin two forced low on full-depth keying
// - Steady-only pin two ignores the envelope
// - Single driver uses same conductance values
// - Framing and select set rate, driver source
// - Link framing parity up to 848 kBd
// - Aux serial pins exchange link signals
module ados_top
  import ados_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic driver_one_carrier_enable_in,
  input wire logic driver_two_carrier_enable_in,
  input wire logic forced_full_depth_keying_in,
  input wire logic driver_one_invert_when_on_in,
  input wire logic driver_one_invert_when_off_in,
  input wire logic driver_two_continuous_wave_only_in,
  input wire logic driver_two_invert_when_on_in,
  input wire logic driver_two_invert_when_off_in,
  input wire logic [P_COND_W-1:0] p_conductance_steady_register_in,
  input wire logic [P_COND_W-1:0] p_conductance_keyed_register_in,
  input wire logic [7:0] n_conductance_register_in,
  input wire logic [7:0] transmit_framing_register_in,
  input wire logic [7:0] transmit_signal_select_register_in,
  input wire logic envelope_in,
  input wire logic aux_serial_input_in,
  input wire logic [7:0] tx_byte_in,
  output logic antenna_drive_pin_one_out,
  output logic antenna_drive_pin_two_out,
  output logic [P_COND_W-1:0] p_array_conductance_one_out,
  output logic [N_COND_W-1:0] n_array_conductance_one_out,
  output logic [P_COND_W-1:0] p_array_conductance_two_out,
  output logic [N_COND_W-1:0] n_array_conductance_two_out,
  output logic aux_serial_output_out,
  output logic bit_tick_out,
  output logic tx_parity_out
);

  ados_state_t st_r;
  ados_state_t st_nxt;
  logic env_eff;
  logic [1:0] drv_sel;
  logic [3:0] aux_sel;
  logic [1:0] speed;
  logic [15:0] bit_len;
  logic [N_COND_W-1:0] n_steady;
  logic [N_COND_W-1:0] n_keyed;

  function automatic logic [P_COND_W-1:0] pick_p(input logic env,
                                                 input logic [P_COND_W-1:0] steady,
                                                 input logic [P_COND_W-1:0] keyed);
    pick_p = env ? steady : keyed;
  endfunction

  function automatic logic [N_COND_W-1:0] pick_n(input logic env,
                                                 input logic [N_COND_W-1:0] steady,
                                                 input logic [N_COND_W-1:0] keyed);
    pick_n = env ? steady : keyed;
  endfunction

  function automatic logic [15:0] rate_cycles(input logic [1:0] sp);
    if (sp == SPEED_106)
    begin
      rate_cycles = BIT_CYC_106;
    end
    else if (sp == SPEED_212)
    begin
      rate_cycles = BIT_CYC_212;
    end
    else if (sp == SPEED_424)
    begin
      rate_cycles = BIT_CYC_424;
    end
    else
    begin
      rate_cycles = BIT_CYC_848;
    end
  endfunction

  assign drv_sel = transmit_signal_select_register_in[TXS_DRV_LSB +: 2];
  assign aux_sel = transmit_signal_select_register_in[TXS_AUX_LSB +: 4];
  assign speed = transmit_framing_register_in[TXF_SPEED_LSB +: 2];
  assign bit_len = rate_cycles(speed);
  assign n_steady = n_conductance_register_in[N_STEADY_LSB +: N_COND_W];
  assign n_keyed = n_conductance_register_in[N_KEYED_LSB +: N_COND_W];

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.div_cnt == CARRIER_HALF_M1)
    begin
      st_nxt.div_cnt = 2'h0;
      st_nxt.carrier = ~st_r.carrier;
    end
    else
    begin
      st_nxt.div_cnt = st_r.div_cnt + 2'h1;
    end
    case (drv_sel)
      DRV_SEL_OFF: env_eff = 1'b0;
      DRV_SEL_INT: env_eff = envelope_in;
      DRV_SEL_AUX: env_eff = aux_serial_input_in;
      default: env_eff = 1'b1;
    endcase
    if (st_r.bit_cnt >= bit_len - 16'h1)
    begin
      st_nxt.bit_cnt = 16'h0;
      st_nxt.bit_tick = 1'b1;
    end
    else
    begin
      st_nxt.bit_cnt = st_r.bit_cnt + 16'h1;
      st_nxt.bit_tick = 1'b0;
    end
    st_nxt.parity = ~^tx_byte_in;
    if (aux_sel == AUX_SEL_ENV)
    begin
      st_nxt.aux_out = env_eff;
    end
    else if (aux_sel == AUX_SEL_CARRIER)
    begin
      st_nxt.aux_out = st_nxt.carrier;
    end
    else
    begin
      st_nxt.aux_out = 1'b0;
    end
    if (!driver_one_carrier_enable_in)
    begin
      st_nxt.pin1 = 1'b0;
      st_nxt.p1 = '0;
      st_nxt.n1 = '0;
    end
    else
    begin
      st_nxt.p1 = pick_p(env_eff, p_conductance_steady_register_in,
                         p_conductance_keyed_register_in);
      st_nxt.n1 = pick_n(env_eff, n_steady, n_keyed);
      if (env_eff)
      begin
        st_nxt.pin1 = st_nxt.carrier ^ driver_one_invert_when_on_in;
      end
      else if (forced_full_depth_keying_in)
      begin
        st_nxt.pin1 = 1'b0;
      end
      else
      begin
        st_nxt.pin1 = st_nxt.carrier ^ driver_one_invert_when_off_in;
      end
    end
    if (!driver_two_carrier_enable_in)
    begin
      st_nxt.pin2 = 1'b0;
      st_nxt.p2 = '0;
      st_nxt.n2 = '0;
    end
    else if (driver_two_continuous_wave_only_in)
    begin
      st_nxt.pin2 = st_nxt.carrier ^ driver_two_invert_when_on_in;
      st_nxt.p2 = p_conductance_steady_register_in;
      st_nxt.n2 = n_steady;
    end
    else
    begin
      st_nxt.p2 = pick_p(env_eff, p_conductance_steady_register_in,
                         p_conductance_keyed_register_in);
      st_nxt.n2 = pick_n(env_eff, n_steady, n_keyed);
      if (env_eff)
      begin
        st_nxt.pin2 = st_nxt.carrier ^ driver_two_invert_when_on_in;
      end
      else if (forced_full_depth_keying_in)
      begin
        st_nxt.pin2 = 1'b0;
      end
      else
      begin
        st_nxt.pin2 = st_nxt.carrier ^ driver_two_invert_when_off_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_r <= ADOS_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign antenna_drive_pin_one_out = st_r.pin1;
  assign antenna_drive_pin_two_out = st_r.pin2;
  assign p_array_conductance_one_out = st_r.p1;
  assign n_array_conductance_one_out = st_r.n1;
  assign p_array_conductance_two_out = st_r.p2;
  assign n_array_conductance_two_out = st_r.n2;
  assign aux_serial_output_out = st_r.aux_out;
  assign bit_tick_out = st_r.bit_tick;
  assign tx_parity_out = st_r.parity;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  a_carrier_toggles: assert property (1'b1 ##1 1'b1 |-> st_r.carrier != $past(st_r.carrier))
    else $error("carrier did not toggle");
  a_pin_one_off: assert property (!driver_one_carrier_enable_in |=> !st_r.pin1 && st_r.p1 == '0)
    else $error("disabled pin one not parked");
  a_pin_two_off: assert property (
    !driver_two_carrier_enable_in |=> !st_r.pin2 && st_r.p2 == '0 && st_r.n2 == '0)
    else $error("disabled pin two not parked");
  a_force_one_low: assert property (
    driver_one_carrier_enable_in && forced_full_depth_keying_in && !env_eff |=> !st_r.pin1)
    else $error("pin one not forced low");
  a_off_keyed_one: assert property (
    driver_one_carrier_enable_in && !forced_full_depth_keying_in && !env_eff
    |=> st_r.pin1 == (st_r.carrier ^ $past(driver_one_invert_when_off_in)))
    else $error("pin one keyed carrier wrong");
  a_force_two_low: assert property (
    driver_two_carrier_enable_in && forced_full_depth_keying_in
    && !driver_two_continuous_wave_only_in && !env_eff |=> !st_r.pin2)
    else $error("pin two not forced low");
  a_cw_only_two: assert property (
    driver_two_carrier_enable_in && driver_two_continuous_wave_only_in
    |=> st_r.pin2 == (st_r.carrier ^ $past(driver_two_invert_when_on_in))
    && st_r.p2 == $past(p_conductance_steady_register_in))
    else $error("steady-only pin two wrong");
  a_invert_on_one: assert property (
    driver_one_carrier_enable_in && env_eff
    |=> st_r.pin1 == (st_r.carrier ^ $past(driver_one_invert_when_on_in)))
    else $error("pin one carrier polarity wrong");
  a_invert_on_two: assert property (
    driver_two_carrier_enable_in && !driver_two_continuous_wave_only_in && env_eff
    |=> st_r.pin2 == (st_r.carrier ^ $past(driver_two_invert_when_on_in)))
    else $error("pin two carrier polarity wrong");
  a_keyed_cond: assert property (
    driver_one_carrier_enable_in && !env_eff
    |=> st_r.p1 == $past(p_conductance_keyed_register_in) && st_r.n1 == $past(n_keyed))
    else $error("keyed conductance wrong");
  a_steady_cond: assert property (
    driver_one_carrier_enable_in && env_eff
    |=> st_r.p1 == $past(p_conductance_steady_register_in) && st_r.n1 == $past(n_steady))
    else $error("steady conductance wrong");
  a_shared_cond: assert property (
    driver_one_carrier_enable_in && driver_two_carrier_enable_in
    && !driver_two_continuous_wave_only_in |=> st_r.p1 == st_r.p2 && st_r.n1 == st_r.n2)
    else $error("driver conductances differ");
  a_aux_carrier: assert property (
    aux_sel == AUX_SEL_CARRIER |=> st_r.aux_out == st_r.carrier)
    else $error("aux output not carrier");
  a_bit_tick_gap: assert property ($rose(st_r.bit_tick) |=> !st_r.bit_tick [*8])
    else $error("bit strobe too close");
  a_parity_odd: assert property (1'b1 |=> ^{st_r.parity, $past(tx_byte_in)} == 1'b1)
    else $error("parity not odd");
  a_aux_follows: assert property (aux_sel == AUX_SEL_ENV |=> st_r.aux_out == $past(env_eff))
    else $error("aux output not envelope");

  c_force_keying: cover property (driver_one_carrier_enable_in && forced_full_depth_keying_in
    && !env_eff ##1 env_eff);
  c_cw_only: cover property (driver_two_carrier_enable_in && driver_two_continuous_wave_only_in);
  c_aux_source: cover property (drv_sel == DRV_SEL_AUX && aux_serial_input_in);
  c_bit_tick: cover property (st_r.bit_tick);

endmodule

/* pkg/ados_pkg.sv */
package ados_pkg;
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int XTAL_FREQ_KHZ = 27120;
  localparam int CARRIER_DIV = 2;
  localparam logic [1:0] CARRIER_HALF_M1 = 2'(CARRIER_DIV / 2 - 1);
  localparam int RATE_106_KBD = 106;
  localparam int RATE_212_KBD = 212;
  localparam int RATE_424_KBD = 424;
  localparam int RATE_848_KBD = 848;
  localparam logic [15:0] BIT_CYC_106 = 16'(CLK_FREQ_KHZ / RATE_106_KBD);
  localparam logic [15:0] BIT_CYC_212 = 16'(CLK_FREQ_KHZ / RATE_212_KBD);
  localparam logic [15:0] BIT_CYC_424 = 16'(CLK_FREQ_KHZ / RATE_424_KBD);
  localparam logic [15:0] BIT_CYC_848 = 16'(CLK_FREQ_KHZ / RATE_848_KBD);
  localparam int P_COND_W = 6;
  localparam int N_COND_W = 4;
  localparam int N_STEADY_LSB = 4;
  localparam int N_KEYED_LSB = 0;
  localparam int TXF_SPEED_LSB = 4;
  localparam int TXS_DRV_LSB = 4;
  localparam int TXS_AUX_LSB = 0;
  localparam logic [1:0] SPEED_106 = 2'h0;
  localparam logic [1:0] SPEED_212 = 2'h1;
  localparam logic [1:0] SPEED_424 = 2'h2;
  localparam logic [1:0] SPEED_848 = 2'h3;
  localparam logic [1:0] DRV_SEL_OFF = 2'h0;
  localparam logic [1:0] DRV_SEL_INT = 2'h1;
  localparam logic [1:0] DRV_SEL_AUX = 2'h2;
  localparam logic [1:0] DRV_SEL_HIGH = 2'h3;
  localparam logic [3:0] AUX_SEL_LOW = 4'h0;
  localparam logic [3:0] AUX_SEL_ENV = 4'h1;
  localparam logic [3:0] AUX_SEL_CARRIER = 4'h2;

  typedef struct packed {
    logic [1:0] div_cnt;
    logic carrier;
    logic [15:0] bit_cnt;
    logic bit_tick;
    logic pin1;
    logic pin2;
    logic [P_COND_W-1:0] p1;
    logic [N_COND_W-1:0] n1;
    logic [P_COND_W-1:0] p2;
    logic [N_COND_W-1:0] n2;
    logic aux_out;
    logic parity;
  } ados_state_t;

  localparam ados_state_t ADOS_RESET = '0;
endpackage

/* testbench/ados_antenna_net.sv */
`timescale 1ns/1ps
module ados_antenna_net (
  input wire logic clk_sys_in,
  input wire logic pin_one_in,
  input wire logic pin_two_in,
  output logic field_on_out
);
  logic p1_r;
  logic p2_r;
  // field only while a pin toggles
  always_ff @(posedge clk_sys_in)
  begin
    p1_r <= pin_one_in;
    p2_r <= pin_two_in;
  end
  assign field_on_out = (p1_r != pin_one_in) || (p2_r != pin_two_in);
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import ados_pkg::*;
  logic clk_sys_in = 0;
  logic sys_rst_in = 1;
  logic [7:0] ctl = 8'h00;
  logic [7:0] sel = 8'h10;
  logic [7:0] fr = 8'h00;
  logic [7:0] nreg = 8'hC3;
  logic [7:0] byt = 8'h00;
  logic [5:0] ps = 6'h2A;
  logic [5:0] pk = 6'h15;
  logic env = 0;
  logic aux = 0;
  logic car;
  logic p1, p2, ao, tick, par, fld;
  logic [5:0] gp1, gp2;
  logic [3:0] gn1, gn2;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  ados_top dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .driver_one_carrier_enable_in(ctl[7]), .driver_two_carrier_enable_in(ctl[6]),
    .forced_full_depth_keying_in(ctl[5]), .driver_one_invert_when_on_in(ctl[4]),
    .driver_one_invert_when_off_in(ctl[3]), .driver_two_continuous_wave_only_in(ctl[2]),
    .driver_two_invert_when_on_in(ctl[1]), .driver_two_invert_when_off_in(ctl[0]),
    .p_conductance_steady_register_in(ps), .p_conductance_keyed_register_in(pk),
    .n_conductance_register_in(nreg), .transmit_framing_register_in(fr),
    .transmit_signal_select_register_in(sel), .envelope_in(env),
    .aux_serial_input_in(aux), .tx_byte_in(byt), .antenna_drive_pin_one_out(p1),
    .antenna_drive_pin_two_out(p2), .p_array_conductance_one_out(gp1),
    .n_array_conductance_one_out(gn1), .p_array_conductance_two_out(gp2),
    .n_array_conductance_two_out(gn2), .aux_serial_output_out(ao),
    .bit_tick_out(tick), .tx_parity_out(par));
  ados_antenna_net net (.clk_sys_in(clk_sys_in), .pin_one_in(p1), .pin_two_in(p2),
    .field_on_out(fld));
  // reference carrier at half the clock
  always @(posedge clk_sys_in or posedge sys_rst_in)
    car <= sys_rst_in ? 1'b0 : ~car;
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fails++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_compared++;
    if (ex !== got)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic step;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic pins;
    logic e, e2, k;
    repeat (2)
    begin
      step;
      e = sel[5:4] == DRV_SEL_OFF ? 1'b0 : sel[5:4] == DRV_SEL_INT ? env :
        sel[5:4] == DRV_SEL_AUX ? aux : 1'b1;
      e2 = ctl[2] | e;
      k = ctl[5] & ~e;
      chk("pin one", 16'(ctl[7] & ~k & (car ^ (e ? ctl[4] : ctl[3]))), 16'(p1));
      chk("pin two", 16'(ctl[6] & (ctl[2] ? car ^ ctl[1] :
        ~k & (car ^ (e ? ctl[1] : ctl[0])))), 16'(p2));
      chk("cond one", ctl[7] ? {e ? ps : pk, e ? nreg[7:4] : nreg[3:0]} : 16'h0,
        16'({gp1, gn1}));
      chk("cond two", ctl[6] ? {e2 ? ps : pk, e2 ? nreg[7:4] : nreg[3:0]} : 16'h0,
        16'({gp2, gn2}));
      chk("aux out", 16'(sel[3:0] == AUX_SEL_ENV ? e : sel[3:0] == AUX_SEL_CARRIER & car),
        16'(ao));
    end
  endtask
  task automatic t_table;
    sel = 8'h10;
    for (int i = 0; i < 128; i++)
    begin
      ctl = {2'b11, i[5:0]};
      env = i[6];
      pins;
    end
    $display("table test done");
  endtask
  task automatic t_single;
    for (int i = 0; i < 12; i++)
    begin
      ctl = {i[1:0], 1'b0, i[3:2] == 2'h1, 2'b00, i[3:2] == 2'h2, 1'b0};
      env = i[2];
      pins;
    end
    $display("single driver test done");
  endtask
  task automatic t_source;
    ctl = 8'hC0;
    for (int i = 0; i < 64; i++)
    begin
      sel = {2'b00, i[1:0], 2'b00, i[3:2]};
      env = i[4];
      aux = i[5];
      pins;
    end
    $display("source test done");
  endtask
  task automatic t_field;
    sel = 8'h12;
    ctl = 8'hE0;
    env = 0;
    repeat (3) step;
    chk("field keyed", 16'h0, 16'(fld));
    env = 1;
    repeat (2) step;
    chk("field on", 16'h1, 16'(fld));
    $display("field test done");
  endtask
  // bit period per speed and parity
  task automatic t_tick;
    int rate [4] = '{RATE_106_KBD, RATE_212_KBD, RATE_424_KBD, RATE_848_KBD};
    int n;
    for (int s = 3; s >= 0; s--)
    begin
      fr = 8'(s << TXF_SPEED_LSB);
      n = 0;
      while (tick !== 1'b1 && n < 1000)
      begin
        step;
        n++;
      end
      n = 0;
      do
      begin
        step;
        n++;
      end while (tick !== 1'b1 && n < 1000);
      chk("bit period", 16'(CLK_FREQ_KHZ / rate[s]), 16'(n));
    end
    for (int b = 0; b < 256; b += 37)
    begin
      byt = 8'(b);
      step;
      chk("parity", 16'(~^byt), 16'(par));
    end
    $display("tick test done");
  endtask
  task automatic t_reset;
    sys_rst_in = 1;
    step;
    chk("reset outs", 16'h0, 16'({p1, p2, ao, tick, par, gp1, gn1}));
    chk("reset cond two", 16'h0, 16'({gp2, gn2}));
    sys_rst_in = 0;
    pins;
    $display("reset test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    #1;
    chk("reset outs", 16'h0, 16'({p1, p2, ao, tick, par, gp1, gn1}));
    chk("reset cond two", 16'h0, 16'({gp2, gn2}));
    sys_rst_in = 0;
    t_table;
    t_single;
    t_source;
    t_field;
    t_tick;
    ctl = 8'hD2;
    t_reset;
    wrap_up;
  end
endmodule
